// file: rtl/pwm_dual.sv
/*
  Dual ten-bit PWM with shared eight-bit timer, APB register access.
  Assumes a single 200 MHz clock and an APB master.
*/
`timescale 1ns/1ps
module pwm_dual (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sleep,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic pwm_five_out,
  output logic pwm_six_out,
  output logic period_match
);
  logic [2:0] tctrl;
  logic [2:0] next_tctrl;
  logic [7:0] period_register;
  logic [7:0] next_period_register;
  logic [7:0] shared_timer_count;
  logic [7:0] next_shared_timer_count;
  logic [5:0] prescaler;
  logic [5:0] next_prescaler;
  logic [9:0] duty_five;
  logic [9:0] next_duty_five;
  logic [9:0] duty_six;
  logic [9:0] next_duty_six;
  logic [1:0] ctrl_five;
  logic [1:0] next_ctrl_five;
  logic [1:0] ctrl_six;
  logic [1:0] next_ctrl_six;
  logic [31:0] next_prdata;
  logic sleep_meta;
  logic sleep_sync;
  logic wr;
  logic running;
  logic advance;
  logic last_phase;
  logic reload;
  logic [1:0] low_bits;
  logic [9:0] time_base;

  // Two-flop sync of the sleep pin
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
    end
    else
    begin
      sleep_meta <= sleep;
      sleep_sync <= sleep_meta;
    end
  end

  // Control register read image
  function automatic logic [31:0] ctrl_image(input logic [1:0] c,
                                              input logic lvl);
    logic [31:0] v;
    v = 32'h0;
    v[pwm_pkg::EN_BIT] = c[1];
    v[pwm_pkg::OUT_BIT] = lvl;
    v[pwm_pkg::POL_BIT] = c[0];
    return v;
  endfunction

  // Duty low read image, low six bits zero
  function automatic logic [31:0] low_image(input logic [9:0] d);
    logic [31:0] v;
    v = 32'h0;
    v[pwm_pkg::DL_MSB:pwm_pkg::DL_LSB] = d[1:0];
    return v;
  endfunction

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr = psel && penable && pwrite;
  assign running = tctrl[pwm_pkg::TON_BIT] && !sleep_sync;

  // Time base low bits from clock phase or prescaler
  always_comb
  begin
    case (tctrl[pwm_pkg::PS_MSB:0])
      pwm_pkg::PS_DIV1:
      begin
        low_bits = prescaler[1:0];
        last_phase = prescaler[1:0] == 2'h3;
      end
      pwm_pkg::PS_DIV4:
      begin
        low_bits = prescaler[3:2];
        last_phase = prescaler[3:0] == 4'hf;
      end
      default:
      begin
        low_bits = prescaler[5:4];
        last_phase = &prescaler;
      end
    endcase
    time_base = {shared_timer_count, low_bits};
  end
  assign advance = running;
  assign reload = running && last_phase
    && shared_timer_count == period_register;
  assign period_match = reload;

  // Timer, prescaler and register next values
  always_comb
  begin
    next_tctrl = tctrl;
    next_period_register = period_register;
    next_prescaler = prescaler;
    next_shared_timer_count = shared_timer_count;
    next_duty_five = duty_five;
    next_duty_six = duty_six;
    next_ctrl_five = ctrl_five;
    next_ctrl_six = ctrl_six;
    if (running)
    begin
      // Phase counter: 4 clocks a tick at 1, 16 at 4, 64 at 16
      if (tctrl[pwm_pkg::PS_MSB:0] == pwm_pkg::PS_DIV1)
        next_prescaler = {4'h0, prescaler[1:0] + 2'h1};
      else if (tctrl[pwm_pkg::PS_MSB:0] == pwm_pkg::PS_DIV4)
        next_prescaler = {2'h0, prescaler[3:0] + 4'h1};
      else
        next_prescaler = prescaler + 6'h01;
      if (last_phase)
      begin
        next_prescaler = 6'h00;
        next_shared_timer_count = reload ? 8'h00
          : shared_timer_count + 8'h01;
      end
    end
    if (wr)
    begin
      if (paddr == pwm_pkg::OFF_TIMER_CTRL)
        next_tctrl = pwdata[2:0];
      else if (paddr == pwm_pkg::OFF_PERIOD)
        next_period_register = pwdata[7:0];
      else if (paddr == pwm_pkg::OFF_TIMER_COUNT)
        next_shared_timer_count = pwdata[7:0];
      else if (paddr == pwm_pkg::OFF_FIVE_CONTROL)
        next_ctrl_five = {pwdata[pwm_pkg::EN_BIT], pwdata[pwm_pkg::POL_BIT]};
      else if (paddr == pwm_pkg::OFF_FIVE_DUTY_HIGH)
        next_duty_five[9:2] = pwdata[7:0];
      else if (paddr == pwm_pkg::OFF_FIVE_DUTY_LOW)
        next_duty_five[1:0] = pwdata[pwm_pkg::DL_MSB:pwm_pkg::DL_LSB];
      else if (paddr == pwm_pkg::OFF_SIX_CONTROL)
        next_ctrl_six = {pwdata[pwm_pkg::EN_BIT], pwdata[pwm_pkg::POL_BIT]};
      else if (paddr == pwm_pkg::OFF_SIX_DUTY_HIGH)
        next_duty_six[9:2] = pwdata[7:0];
      else if (paddr == pwm_pkg::OFF_SIX_DUTY_LOW)
        next_duty_six[1:0] = pwdata[pwm_pkg::DL_MSB:pwm_pkg::DL_LSB];
    end
  end

  // Read data mux, registered
  always_comb
  begin
    next_prdata = 32'h0;
    if (paddr == pwm_pkg::OFF_TIMER_CTRL)
      next_prdata = {29'h0, tctrl};
    else if (paddr == pwm_pkg::OFF_PERIOD)
      next_prdata = {24'h0, period_register};
    else if (paddr == pwm_pkg::OFF_TIMER_COUNT)
      next_prdata = {24'h0, shared_timer_count};
    else if (paddr == pwm_pkg::OFF_FIVE_CONTROL)
      next_prdata = ctrl_image(ctrl_five, pwm_five_out);
    else if (paddr == pwm_pkg::OFF_FIVE_DUTY_HIGH)
      next_prdata = {24'h0, duty_five[9:2]};
    else if (paddr == pwm_pkg::OFF_FIVE_DUTY_LOW)
      next_prdata = low_image(duty_five);
    else if (paddr == pwm_pkg::OFF_SIX_CONTROL)
      next_prdata = ctrl_image(ctrl_six, pwm_six_out);
    else if (paddr == pwm_pkg::OFF_SIX_DUTY_HIGH)
      next_prdata = {24'h0, duty_six[9:2]};
    else if (paddr == pwm_pkg::OFF_SIX_DUTY_LOW)
      next_prdata = low_image(duty_six);
  end

  // Register state; duty bits untouched by this reset
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      tctrl <= 3'h0;
      period_register <= pwm_pkg::PERIOD_RESET;
      shared_timer_count <= 8'h00;
      prescaler <= 6'h00;
      ctrl_five <= 2'h0;
      ctrl_six <= 2'h0;
      prdata <= 32'h0;
    end
    else
    begin
      tctrl <= next_tctrl;
      period_register <= next_period_register;
      shared_timer_count <= next_shared_timer_count;
      prescaler <= next_prescaler;
      ctrl_five <= next_ctrl_five;
      ctrl_six <= next_ctrl_six;
      prdata <= next_prdata;
    end
  end

  // Duty storage keeps its value across reset
  always_ff @(posedge clk)
  begin
    duty_five <= next_duty_five;
    duty_six <= next_duty_six;
  end

  pwm_channel five (
    .clk(clk),
    .resetn(resetn),
    .duty_value(duty_five),
    .module_enable(ctrl_five[1]),
    .polarity_select(ctrl_five[0]),
    .reload(reload),
    .advance(advance),
    .time_base(time_base),
    .output_level(pwm_five_out)
  );

  pwm_channel six (
    .clk(clk),
    .resetn(resetn),
    .duty_value(duty_six),
    .module_enable(ctrl_six[1]),
    .polarity_select(ctrl_six[0]),
    .reload(reload),
    .advance(advance),
    .time_base(time_base),
    .output_level(pwm_six_out)
  );

  AST_SLEEP_FREEZE: assert property (@(posedge clk)
    disable iff (!resetn) sleep_sync && !wr |=> $stable(shared_timer_count))
    else $error("timer moved during sleep");
  AST_DUTY_KEEP: assert property (@(posedge clk)
    !wr |=> $stable(duty_five))
    else $error("duty changed without write");
  AST_WRAP: assert property (@(posedge clk)
    disable iff (!resetn) reload && !wr |=> shared_timer_count == 8'h00)
    else $error("timer did not wrap at period match");
  AST_LOW_ZERO: assert property (@(posedge clk)
    disable iff (!resetn) psel && paddr == pwm_pkg::OFF_FIVE_DUTY_LOW
    |=> prdata[5:0] == 6'h0)
    else $error("unimplemented duty bits nonzero");
  AST_HIGH_WRITE: assert property (@(posedge clk)
    disable iff (!resetn) wr && paddr == pwm_pkg::OFF_FIVE_DUTY_HIGH
    |=> duty_five[9:2] == $past(pwdata[7:0]))
    else $error("duty high not stored");
endmodule // pwm_dual

// file: rtl/pwm_pkg.sv
/*
  Package for the dual ten-bit PWM block: register offsets, field
  positions, reset values and prescale codes.
  Assumes a 32-bit APB slave with word-aligned registers.
*/
package pwm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_TIMER_CTRL = 8'h00;
  localparam logic [7:0] OFF_PERIOD = 8'h04;
  localparam logic [7:0] OFF_TIMER_COUNT = 8'h08;
  localparam logic [7:0] OFF_FIVE_CONTROL = 8'h10;
  localparam logic [7:0] OFF_FIVE_DUTY_HIGH = 8'h14;
  localparam logic [7:0] OFF_FIVE_DUTY_LOW = 8'h18;
  localparam logic [7:0] OFF_SIX_CONTROL = 8'h20;
  localparam logic [7:0] OFF_SIX_DUTY_HIGH = 8'h24;
  localparam logic [7:0] OFF_SIX_DUTY_LOW = 8'h28;
  // Control register fields
  localparam int EN_BIT = 7;
  localparam int OUT_BIT = 5;
  localparam int POL_BIT = 4;
  // Duty low field position
  localparam int DL_MSB = 7;
  localparam int DL_LSB = 6;
  // Timer control fields
  localparam int TON_BIT = 2;
  localparam int PS_MSB = 1;
  // Prescale codes: 1, 4, 16
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV4 = 2'h1;
  localparam logic [1:0] PS_DIV16 = 2'h2;
  // Reset values
  localparam logic [7:0] PERIOD_RESET = 8'hff;
  localparam logic [9:0] DUTY_RESET = 10'h000;
endpackage

// file: rtl/pwm_channel.sv
/*
  One PWM channel: buffered duty value, compare and polarity.
  Assumes time base and reload strobe from the shared timer.
*/
`timescale 1ns/1ps
module pwm_channel (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [9:0] duty_value,
  input wire logic module_enable,
  input wire logic polarity_select,
  input wire logic reload,
  input wire logic advance,
  input wire logic [9:0] time_base,
  output logic output_level
);
  logic [9:0] applied;
  logic [9:0] next_applied;
  logic active;
  logic next_output_level;

  // Apply new duty only at period match
  always_comb
  begin
    next_applied = reload ? duty_value : applied;
    active = module_enable && (time_base < applied);
    next_output_level = output_level;
    if (advance)
      next_output_level = active ^ polarity_select;
  end

  // Registers; hold when frozen
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      applied <= pwm_pkg::DUTY_RESET;
      output_level <= 1'b0;
    end
    else
    begin
      applied <= next_applied;
      output_level <= next_output_level;
    end
  end

  AST_RELOAD: assert property (@(posedge clk)
    disable iff (!resetn) reload |=> applied == $past(duty_value))
    else $error("duty not applied at period match");
  AST_HOLD: assert property (@(posedge clk)
    disable iff (!resetn) !reload |=> $stable(applied))
    else $error("duty changed outside period match");
  AST_POL: assert property (@(posedge clk)
    disable iff (!resetn) advance && !module_enable
    |=> output_level == $past(polarity_select))
    else $error("disabled output not inactive");
  AST_FREEZE: assert property (@(posedge clk)
    disable iff (!resetn) !advance |=> $stable(output_level))
    else $error("output moved while frozen");
endmodule // pwm_channel

// file: tb/ten_bit_pwm_duty_regs_tb.sv
/*
  Self-checking bench for the dual ten-bit PWM: register map, duty
  split, reset keeping, time base, polarity, enable and sleep freeze.
  Assumes pwm_dual with an always-ready APB slave and the pwm_pkg map.
*/
`timescale 1ns/1ps
module ten_bit_pwm_duty_regs_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic sleep = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pwm_five_out;
  logic pwm_six_out;
  logic period_match;
  int err_count = 0;
  int checks = 0;
  logic [31:0] rd;
  logic [31:0] rd2;
  int n;
  int h;

  // Clock of 5 ns
  always #2.5 clk = ~clk;

  pwm_dual dut (.clk(clk), .resetn(resetn), .sleep(sleep), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_five_out(pwm_five_out), .pwm_six_out(pwm_six_out),
    .period_match(period_match));

  // Closing report
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Compare and count
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer, held until pready at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    q = prdata;
    check("pslverr", {31'h0, pslverr}, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 50)
    begin
      err_count++;
      print_verdict();
    end
  endtask

  // Period length and high samples of channel five between matches
  task automatic measure(output int len, output int highs);
    int i;
    for (i = 0; i < 5000 && period_match !== 1'b1; i++)
      @(negedge clk);
    len = 0;
    highs = 0;
    do
    begin
      @(negedge clk);
      len++;
      highs += int'(pwm_five_out === 1'b1);
    end
    while (period_match !== 1'b1 && len < 5000);
    if (i == 5000 || len == 5000)
    begin
      err_count++;
      print_verdict();
    end
  endtask

  // Load channel five duty, wait for it to apply, then measure
  task automatic run_duty(input logic [9:0] duty, input logic [7:0] ctl,
                          input int exp_len, input int exp_high);
    apb(1'b1, pwm_pkg::OFF_FIVE_DUTY_HIGH, {24'h0, duty[9:2]}, rd);
    apb(1'b1, pwm_pkg::OFF_FIVE_DUTY_LOW, {24'h0, duty[1:0], 6'h0}, rd);
    apb(1'b1, pwm_pkg::OFF_FIVE_CONTROL, {24'h0, ctl}, rd);
    measure(n, h);
    measure(n, h);
    check("period", n, exp_len);
    check("active", h, exp_high);
  endtask

  // Register map, reset values and field layout
  task automatic scen_regs();
    apb(1'b0, pwm_pkg::OFF_FIVE_CONTROL, 32'h0, rd);
    check("ctl5 reset", rd, 32'h0);
    apb(1'b0, pwm_pkg::OFF_PERIOD, 32'h0, rd);
    check("period reset", rd, {24'h0, pwm_pkg::PERIOD_RESET});
    apb(1'b1, pwm_pkg::OFF_SIX_DUTY_HIGH, 32'hffff_ffa5, rd);
    apb(1'b1, pwm_pkg::OFF_SIX_DUTY_LOW, 32'hffff_ffff, rd);
    apb(1'b0, pwm_pkg::OFF_SIX_DUTY_HIGH, 32'h0, rd);
    check("dh6", rd, 32'ha5);
    apb(1'b0, pwm_pkg::OFF_SIX_DUTY_LOW, 32'h0, rd);
    check("dl6", rd, 32'hc0);
    apb(1'b1, pwm_pkg::OFF_SIX_CONTROL, 32'hffff_ffff, rd);
    apb(1'b0, pwm_pkg::OFF_SIX_CONTROL, 32'h0, rd);
    check("ctl6", rd & 32'hffff_ffdf, 32'h90);
    apb(1'b1, 8'hfc, 32'h1234, rd);
    apb(1'b0, 8'hfc, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    // Reset again: duty kept, control cleared
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, pwm_pkg::OFF_SIX_DUTY_HIGH, 32'h0, rd);
    check("dh6 kept", rd, 32'ha5);
    apb(1'b0, pwm_pkg::OFF_SIX_DUTY_LOW, 32'h0, rd);
    check("dl6 kept", rd, 32'hc0);
    apb(1'b0, pwm_pkg::OFF_SIX_CONTROL, 32'h0, rd);
    check("ctl6 cleared", rd, 32'h0);
  endtask

  // Waveforms: full resolution, prescale 4, polarity and enable
  task automatic scen_wave();
    apb(1'b1, pwm_pkg::OFF_TIMER_CTRL, {29'h0, 1'b1, pwm_pkg::PS_DIV1}, rd);
    run_duty(10'h201, 8'h80, 1024, 513);
    // Channel six disabled, active-low: output parks high
    apb(1'b1, pwm_pkg::OFF_SIX_CONTROL, 32'h10, rd);
    apb(1'b0, pwm_pkg::OFF_SIX_CONTROL, 32'h0, rd);
    check("ctl6 out", rd, 32'h30);
    check("out6", {31'h0, pwm_six_out}, 32'h1);
    apb(1'b1, pwm_pkg::OFF_PERIOD, 32'h3, rd);
    apb(1'b1, pwm_pkg::OFF_TIMER_CTRL, {29'h0, 1'b1, pwm_pkg::PS_DIV4}, rd);
    run_duty(10'h006, 8'h80, 64, 24);
    run_duty(10'h006, 8'h90, 64, 40);
    run_duty(10'h006, 8'h00, 64, 0);
    run_duty(10'h006, 8'h10, 64, 64);
    apb(1'b0, pwm_pkg::OFF_FIVE_CONTROL, 32'h0, rd);
    check("ctl5 out", rd, 32'h30);
    apb(1'b1, pwm_pkg::OFF_TIMER_CTRL, {29'h0, 1'b1, pwm_pkg::PS_DIV16}, rd);
    run_duty(10'h005, 8'h80, 256, 80);
    // Spare prescale code behaves as sixteen
    apb(1'b1, pwm_pkg::OFF_TIMER_CTRL, 32'h7, rd);
    run_duty(10'h005, 8'h80, 256, 80);
  endtask

  // Sleep freezes count and output
  task automatic scen_sleep();
    logic lvl;
    @(posedge clk);
    sleep <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, pwm_pkg::OFF_TIMER_COUNT, 32'h0, rd);
    lvl = pwm_five_out;
    repeat (100) @(posedge clk);
    apb(1'b0, pwm_pkg::OFF_TIMER_COUNT, 32'h0, rd2);
    check("frozen count", rd2, rd);
    check("frozen out", {31'h0, pwm_five_out}, {31'h0, lvl});
    sleep <= 1'b0;
    run_duty(10'h005, 8'h80, 256, 80);
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    scen_regs();
    scen_wave();
    scen_sleep();
    print_verdict();
  end
endmodule // ten_bit_pwm_duty_regs_tb
